// File: core/ntio_map.svh
/*
 holds named constants for the network terminal map: object ids, counts,
 function selection codes and synchroniser depth.
 assumes inclusion by bare name from design files.
*/
`ifndef NTIO_MAP_SVH
`define NTIO_MAP_SVH
`define NTIO_NUM_IN 12
`define NTIO_NUM_OUT 7
`define NTIO_BI_OUT_BASE 7'h64
`define NTIO_BI_IN_LAST 7'h0b
`define NTIO_BI_OUT_LAST 7'h6a
`define NTIO_BO_LAST 7'h06
`define NTIO_FSEL_NET_A 8'h52
`define NTIO_FSEL_NET_B 8'hb6
`define NTIO_INACTIVE 1'h0
`define NTIO_SYNC_DEPTH 3
`endif

// File: core/ntio_pkg.sv
/*
 holds the types shared by the network terminal map.
 assumes ntio_map.svh is on the include path.
*/
`include "ntio_map.svh"
package ntio_pkg;
    typedef struct packed {
        logic [6:0] id;   // object instance
        logic wr;         // write strobe
        logic rd;         // read strobe
        logic is_out;     // 1 binary output object, 0 binary input object
        logic value;      // written present value
    } ntio_req_t;
    typedef struct packed {
        logic valid;      // answer strobe
        logic err;        // refused or unknown object
        logic value;      // present value
    } ntio_rsp_t;
    typedef enum logic [0:0] {NTIO_IDLE, NTIO_ANSWER} ntio_state_t;
endpackage

// File: core/ntio_sync.sv
/*
 three-stage synchroniser for a bus of pin levels; a change is accepted once
 the second and third stages agree.
 assumes one clock, synchronous active-low reset, clock enable.
*/
`timescale 1ns/1ns
`include "ntio_map.svh"
module ntio_sync import ntio_pkg::*; #(
    parameter int W = `NTIO_NUM_IN
) (
    input wire logic mclk,            // system clock
    input wire logic reset_n,         // synchronous reset
    input wire logic ce,              // clock enable
    input wire logic [W-1:0] din,     // raw pin levels
    output logic [W-1:0] dout         // filtered levels
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [W-1:0] q_next;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
            end
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else if (ce) begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end
    assign dout = q_reg;
endmodule

// File: core/ntio_top.sv
/*
 maps drive control terminals onto network binary objects: input objects
 read terminal levels, output objects force output terminals.
 assumes a protocol engine issues single-cycle requests; pins are async.
*/
// What this block does
// - each object present value is one bit, zero inactive, one active
// - input objects 0..11 report the twelve input terminals in fixed order
// - with expansion card fitted, objects 0,1,3,4,5,6,8,11 read card terminals
// - input objects 100..106 report actual driven level of seven outputs
// - input objects are read-only; writes are refused
// - output objects 0..6 are writable and drive the seven outputs in order
// - a written output object drives its terminal only at selection 82 or 182
// - network control works in every operation mode and command source
`timescale 1ns/1ns
`include "ntio_map.svh"
module ntio_top import ntio_pkg::*; (
    input wire logic mclk,                          // 100 MHz clock
    input wire logic reset_n,                       // sync reset, active low
    input wire logic ce,                            // clock enable
    input wire logic fwd_start_in,                  // forward start pin
    input wire logic rev_start_in,                  // reverse start pin
    input wire logic current_input_select_in,       // current input select pin
    input wire logic second_function_in,            // second function pin
    input wire logic low_speed_in,                  // low speed pin
    input wire logic mid_speed_in,                  // mid speed pin
    input wire logic high_speed_in,                 // high speed pin
    input wire logic inching_in,                    // inching pin
    input wire logic output_stop_in,                // output stop pin
    input wire logic start_hold_in,                 // start hold pin
    input wire logic clear_fault_in,                // fault clear pin
    input wire logic restart_select_in,             // restart select pin
    input wire logic card_fitted,                   // expansion card present
    input wire logic [7:0] card_x_in,               // card terminals x1..x8 at [0..7]
    input wire logic [6:0] func_out,                // normal function output levels
    input wire logic [55:0] fsel,                   // per-output selection, 8 bits each
    input wire ntio_req_t req,                      // object request
    output ntio_rsp_t rsp,                          // object answer
    output logic running_out,                       // running terminal
    output logic speed_reached_out,                 // speed reached terminal
    output logic power_dip_out,                     // power dip terminal
    output logic overload_out,                      // overload terminal
    output logic freq_detect_out,                   // frequency detect terminal
    output logic relay_one_out,                     // relay one terminal
    output logic relay_two_out                      // relay two terminal
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [19:0] raw_pins, sync_pins;
    logic [11:0] term_in, card_in;
    logic card_ok;
    assign raw_pins = {card_x_in, restart_select_in, clear_fault_in, start_hold_in,
        output_stop_in, inching_in, high_speed_in, mid_speed_in, low_speed_in,
        second_function_in, current_input_select_in, rev_start_in, fwd_start_in};
    ntio_sync #(.W(20)) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .din(raw_pins),
        .dout(sync_pins)
    );
    // card presence is a strap-like level, synchronised locally
    logic [2:0] card_sync_reg, card_sync_next;
    logic card_reg, card_next;
    always_comb begin
        card_sync_next = {card_sync_reg[1:0], card_fitted};
        card_next = (card_sync_reg[1] == card_sync_reg[2]) ? card_sync_reg[2] : card_reg;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            card_sync_reg <= '0;
            card_reg <= `NTIO_INACTIVE;
        end else if (ce) begin
            card_sync_reg <= card_sync_next;
            card_reg <= card_next;
        end
    end
    assign card_ok = card_reg;
    // ------------------------------------------------------------
    // input object view
    // ------------------------------------------------------------
    // card terminal swap
    always_comb begin
        card_in = sync_pins[11:0];
        card_in[0] = sync_pins[12];
        card_in[1] = sync_pins[13];
        card_in[3] = sync_pins[17];
        card_in[4] = sync_pins[14];
        card_in[5] = sync_pins[15];
        card_in[6] = sync_pins[16];
        card_in[8] = sync_pins[19];
        card_in[11] = sync_pins[18];
    end
    assign term_in = card_ok ? card_in : sync_pins[11:0];
    // ------------------------------------------------------------
    // output objects and terminal drive
    // ------------------------------------------------------------
    // drive follows a write in the same edge, so readback never lags the command
    logic [6:0] cmd_reg, cmd_next, drv_reg, drv_next, net_sel;
    genvar g;
    generate
        for (g = 0; g < `NTIO_NUM_OUT; g++) begin : g_out
            assign net_sel[g] = (fsel[g*8 +: 8] == `NTIO_FSEL_NET_A)
                || (fsel[g*8 +: 8] == `NTIO_FSEL_NET_B);
            always_comb begin
                cmd_next[g] = cmd_reg[g];
                if (req.wr && req.is_out && req.id == 7'(g)) begin
                    cmd_next[g] = req.value;
                end
                drv_next[g] = net_sel[g] ? cmd_next[g] : func_out[g];
            end
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cmd_reg <= '0;
            drv_reg <= '0;
        end else if (ce) begin
            cmd_reg <= cmd_next;
            drv_reg <= drv_next;
        end
    end
    assign {relay_two_out, relay_one_out, freq_detect_out, overload_out,
        power_dip_out, speed_reached_out, running_out} = drv_reg;
    // ------------------------------------------------------------
    // request answer
    // ------------------------------------------------------------
    // one answer per request, no queue; back-to-back requests need no gap
    ntio_state_t st_reg, st_next;
    ntio_rsp_t rsp_reg, rsp_next;
    logic [6:0] out_idx;
    assign out_idx = req.id - `NTIO_BI_OUT_BASE;
    always_comb begin
        st_next = NTIO_IDLE;
        rsp_next = '0;
        case (st_reg)
            NTIO_IDLE, NTIO_ANSWER: begin
                if (req.rd || req.wr) begin
                    st_next = NTIO_ANSWER;
                    rsp_next.valid = 1'b1;
                    rsp_next.err = 1'b1;
                    if (req.is_out) begin
                        if (req.id <= `NTIO_BO_LAST) begin
                            rsp_next.err = 1'b0;
                            rsp_next.value = req.wr ? req.value : cmd_reg[req.id[2:0]];
                        end
                    // a read that also writes an input object is refused as a write
                    end else if (req.rd && !req.wr) begin
                        if (req.id <= `NTIO_BI_IN_LAST) begin
                            rsp_next.err = 1'b0;
                            rsp_next.value = term_in[req.id[3:0]];
                        end else if (req.id >= `NTIO_BI_OUT_BASE
                            && req.id <= `NTIO_BI_OUT_LAST) begin
                            rsp_next.err = 1'b0;
                            rsp_next.value = drv_reg[out_idx[2:0]];
                        end
                    end
                    // input object writes keep err set
                end
            end
            default: begin
                st_next = NTIO_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg <= NTIO_IDLE;
            rsp_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
            rsp_reg <= rsp_next;
        end
    end
    assign rsp = rsp_reg;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_RO_INPUT: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.wr && !req.is_out |=> rsp.valid && rsp.err)
        else $error("input object write not refused");
    AST_DRIVE_NET: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && net_sel[0] |=> running_out == $past(cmd_next[0]))
        else $error("networked terminal not following command");
    AST_DRIVE_FUNC: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && !net_sel[1] |=> speed_reached_out == $past(func_out[1]))
        else $error("normal terminal not following its function");
    AST_BO_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.wr && req.is_out && req.id == 7'h02 && !req.rd
        |=> cmd_reg[2] == $past(req.value) && rsp.valid && !rsp.err)
        else $error("output object write lost");
    AST_BI_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.rd && !req.wr && !req.is_out && req.id == `NTIO_BI_OUT_BASE
        |=> rsp.valid && rsp.value == $past(running_out))
        else $error("output state object mismatch");
    AST_BI_IN: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.rd && !req.wr && !req.is_out && req.id == 7'h02
        |=> rsp.valid && rsp.value == $past(term_in[2]))
        else $error("input object mismatch");
    AST_CARD: assert property (@(posedge mclk) disable iff (!reset_n)
        card_ok |-> term_in[11] == sync_pins[18] && term_in[3] == sync_pins[17])
        else $error("card terminal swap wrong");
    AST_NET_READBACK: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && $past(ce) && net_sel[5] && $past(net_sel[5])
        && req.rd && !req.wr && !req.is_out && req.id == `NTIO_BI_OUT_LAST - 7'h01
        |=> rsp.valid && rsp.value == $past(cmd_reg[5]))
        else $error("readback of networked terminal wrong");
    AST_BO_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.wr && req.is_out && req.id > `NTIO_BO_LAST
        |=> rsp.valid && rsp.err && $stable(cmd_reg))
        else $error("write beyond output objects accepted");
    AST_REFUSED_INACTIVE: assert property (@(posedge mclk) disable iff (!reset_n)
        rsp.valid && rsp.err |-> rsp.value == `NTIO_INACTIVE)
        else $error("refused answer carries an active value");
    AST_BI_GAP: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && req.rd && !req.wr && !req.is_out && req.id > `NTIO_BI_IN_LAST
        && req.id < `NTIO_BI_OUT_BASE |=> rsp.valid && rsp.err)
        else $error("unknown input object answered");
endmodule

// File: verification/ntio_client.sv
/*
 holds a behavioural network client that issues object requests.
 assumes the map answers one edge after it takes a request.
*/
`timescale 1ns/1ns
module ntio_client import ntio_pkg::*; (
    input wire logic mclk, // system clock
    output ntio_req_t req, // request to the map
    input wire ntio_rsp_t rsp // answer from the map
);
    initial req = '0;
    // one pulse per request, answer taken one edge later
    task automatic xfer(input logic [6:0] id, input logic o, w, v, output ntio_rsp_t r);
        @(posedge mclk);
        #1 req = '{id: id, wr: w, rd: !w, is_out: o, value: v};
        @(posedge mclk);
        #1 r = rsp;
        // idle fields are scrambled, not left at the old request
        req = '{id: ~id, wr: 1'h0, rd: 1'h0, is_out: ~o, value: ~v};
    endtask
endmodule

// File: verification/network_terminal_io_map_tb.sv
/*
 holds the self-checking bench for the network terminal map.
 assumes ntio_client as the network side and a 100 MHz clock.
*/
`timescale 1ns/1ns
module network_terminal_io_map_tb;
    import ntio_pkg::*;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic [11:0] pins = 12'h000;
    logic card_fitted = 1'h0;
    logic [7:0] card_x_in = 8'h00;
    logic [6:0] func_out = 7'h00;
    logic [55:0] fsel = 56'h0;
    ntio_req_t req;
    ntio_rsp_t rsp, r;
    wire [6:0] term;
    int err_count = 0;
    int cmp_count = 0;
    int objs[8] = '{0, 1, 3, 4, 5, 6, 8, 11};
    int xbit[8] = '{0, 1, 5, 2, 3, 4, 7, 6};
    logic [6:0] mask = 7'h63;

    always #5 mclk = ~mclk;

    ntio_top uut (.mclk(mclk), .reset_n(reset_n), .ce(1'h1),
        .fwd_start_in(pins[0]), .rev_start_in(pins[1]), .current_input_select_in(pins[2]),
        .second_function_in(pins[3]), .low_speed_in(pins[4]), .mid_speed_in(pins[5]),
        .high_speed_in(pins[6]), .inching_in(pins[7]), .output_stop_in(pins[8]),
        .start_hold_in(pins[9]), .clear_fault_in(pins[10]), .restart_select_in(pins[11]),
        .card_fitted(card_fitted), .card_x_in(card_x_in), .func_out(func_out), .fsel(fsel),
        .req(req), .rsp(rsp), .running_out(term[0]), .speed_reached_out(term[1]),
        .power_dip_out(term[2]), .overload_out(term[3]), .freq_detect_out(term[4]),
        .relay_one_out(term[5]), .relay_two_out(term[6]));
    ntio_client client (.mclk(mclk), .req(req), .rsp(rsp));

    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // answer must be valid, error flag and value as given
    task automatic acc(input int id, input logic o, w, v, e, ev);
        client.xfer(id[6:0], o, w, v, r);
        chk($sformatf("object %0d", id), {4'h0, 1'h1, e, ev}, {4'h0, r.valid, r.err, r.value});
    endtask

    task automatic settle();
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge mclk);
        #1 reset_n = 1'h1;
        chk("terminals after reset", 7'h00, term);
        for (int i = 0; i < 12; i++) begin
            pins = 12'h001 << i;
            settle();
            for (int j = 0; j < 12; j++) acc(j, 1'h0, 1'h0, 1'h0, 1'h0, j == i);
        end
        $display("test input terminals done");
        pins = 12'hfff;
        card_fitted = 1'h1;
        for (int k = 0; k < 8; k++) begin
            card_x_in = 8'h01 << xbit[k];
            settle();
            for (int m = 0; m < 8; m++) acc(objs[m], 1'h0, 1'h0, 1'h0, 1'h0, m == k);
            acc(2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        end
        $display("test card terminals done");
        for (int g = 0; g < 7; g++) begin
            func_out = 7'h01 << g;
            settle();
            chk("terminals follow function", func_out, term);
            for (int j = 0; j < 7; j++) acc(100 + j, 1'h0, 1'h0, 1'h0, 1'h0, j == g);
        end
        $display("test output states done");
        acc(2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        acc(2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        acc(101, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
        acc(12, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        acc(7, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
        $display("test refusals done");
        fsel = {8'hb6, 8'h52, 8'h00, 8'hb5, 8'h53, 8'hb6, 8'h52};
        func_out = 7'h7f;
        for (int g = 0; g < 7; g++) acc(g, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        settle();
        chk("terminals commanded low", ~mask, term);
        for (int j = 0; j < 7; j++) acc(100 + j, 1'h0, 1'h0, 1'h0, 1'h0, !mask[j]);
        func_out = 7'h00;
        for (int g = 0; g < 7; g++) acc(g, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
        settle();
        chk("terminals commanded high", mask, term);
        for (int j = 0; j < 7; j++) acc(100 + j, 1'h0, 1'h0, 1'h0, 1'h0, mask[j]);
        for (int g = 0; g < 7; g++) acc(g, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
        $display("test network control done");
        print_verdict();
    end
endmodule
